// ==== ast_tx.sv ====
// Transmit half of the async serial unit with its register port.
// Assumes a bus master on ref_clk_i and a receiver buffer on rx_data_i.
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ast_tx (
   input  wire logic             ref_clk_i,   // Bus-rate clock
   input  wire logic             reset_n_i,   // Async reset, active low
   input  wire ast_pkg::ast_bus_s bus_i,      // Register request
   input  wire logic [7:0]       rx_data_i,   // Receive buffer contents
   output var  logic [7:0]       rd_data_o,   // Read data, one cycle late
   output var  logic             txd_o,       // Serial output
   output var  logic             txd_oe_o     // Transmitter owns the pin
);
   // All state of the transmitter except the baud divider
   typedef struct packed {
      logic [12:0]        sbr;                // Baud modulus
      logic               two;                // two_stop_sel
      logic               nine;               // Nine-bit format
      logic               tx_on;              // tx_on
      logic               brk_req;            // break_request
      logic               lng;                // long_break_sel
      logic               pol;                // tx_polarity_flip
      logic               t8;                 // Ninth bit to send
      logic [7:0]         tbuf;               // Transmit buffer
      logic               tbuf_t8;            // Ninth bit of buffer
      logic               full;               // Buffer holds a character
      logic               done;               // shift_done_flag
      logic               armed;              // Status read seen
      logic               idle_q;             // Idle frame queued
      logic               brk_q;              // Break frame queued
      ast_pkg::ast_mode_e mode;               // Shifter contents
      logic [11:0]        sh;                 // Shift register
      logic [3:0]         cnt;                // Bits left after this
      logic               line;               // Level before flip
      logic               txd;                // Level on the pin
      logic               own;                // Pin ownership
      logic [7:0]         rdata;              // Read answer
   } ast_state_s;

   ast_state_s st_r;                          // Current state
   ast_state_s st_nxt;                        // Next state
   logic       bit_tick;                      // One pulse per bit time
   logic       ld_data;                       // Data enters shifter
   logic       ld_brk;                        // Break enters shifter
   logic       ld_mark;                       // Idle frame enters shifter
   logic       done_set;                      // Shifter finishes this tick
   logic [11:0] frame;                        // Data frame image

   // ****************************************************
   // Baud generator
   // ****************************************************
   // Shared bus-clock divider; its tick paces every bit
   ast_baud_gen #(
      .SBR_W (ast_pkg::SBR_W),
      .OS    (ast_pkg::OVERSAMPLE)
   ) u_baud (
      .ref_clk_i  (ref_clk_i),
      .reset_n_i  (reset_n_i),
      .sbr_i      (st_r.sbr),
      .bit_tick_o (bit_tick)
   );

   // ****************************************************
   // Next-state logic
   // ****************************************************
   // Shifter first, then register writes so sets win
   always_comb begin
      st_nxt  = st_r;
      ld_data = 1'b0;
      ld_brk  = 1'b0;
      ld_mark = 1'b0;
      done_set = 1'b0;
      // Start low, data lsb first, stops high
      frame = st_r.nine ? {2'b11, st_r.tbuf_t8, st_r.tbuf, 1'b0}
                        : {3'b111, st_r.tbuf, 1'b0};
      st_nxt.rdata = 8'h00;

      // Shifter paced by the bit tick
      if (bit_tick) begin
         if (st_r.cnt != 4'h0) begin
            // Next bit; break frames shift in zeros
            st_nxt.line = st_r.sh[0];
            st_nxt.sh   = {st_r.mode != ast_pkg::MODE_BREAK, st_r.sh[11:1]};
            st_nxt.cnt  = st_r.cnt - 4'h1;
         end else if (st_r.idle_q) begin
            // Preamble or queued idle: a frame of ones
            ld_mark       = 1'b1;
            st_nxt.idle_q = 1'b0;
            st_nxt.mode   = ast_pkg::MODE_MARK;
            st_nxt.line   = 1'b1;
            st_nxt.sh     = 12'hfff;
            st_nxt.cnt    = ast_pkg::frame_len(st_r.nine, st_r.two) - 4'h1;
         end else if (st_r.brk_q) begin
            // Break frame; requeue while request stays one
            ld_brk       = 1'b1;
            st_nxt.brk_q = st_r.brk_req;
            st_nxt.mode  = ast_pkg::MODE_BREAK;
            st_nxt.line  = 1'b0;
            st_nxt.sh    = 12'h000;
            st_nxt.cnt   = ast_pkg::break_len(st_r.nine, st_r.two, st_r.lng) - 4'h1;
         end else if (st_r.full && st_r.tx_on) begin
            // Buffer moves into the shifter, buffer empty again
            ld_data     = 1'b1;
            st_nxt.full = 1'b0;
            st_nxt.mode = ast_pkg::MODE_DATA;
            st_nxt.line = frame[0];
            st_nxt.sh   = {1'b1, frame[11:1]};
            st_nxt.cnt  = ast_pkg::frame_len(st_r.nine, st_r.two) - 4'h1;
         end else begin
            // Nothing waiting: finish and idle high
            if (st_r.mode != ast_pkg::MODE_IDLE) begin
               done_set    = 1'b1;
               st_nxt.done = 1'b1;
            end
            st_nxt.mode = ast_pkg::MODE_IDLE;
            st_nxt.line = 1'b1;
         end
      end

      // Register reads
      if (bus_i.rd) begin
         unique case (bus_i.addr)
            ast_pkg::OFS_BAUD_HI: begin
               st_nxt.rdata = {2'b00, st_r.two, st_r.sbr[12:8]};
            end
            ast_pkg::OFS_BAUD_LO: begin
               st_nxt.rdata = st_r.sbr[7:0];
            end
            ast_pkg::OFS_CTRL1: begin
               st_nxt.rdata[ast_pkg::NINE_BIT] = st_r.nine;
            end
            ast_pkg::OFS_CTRL2: begin
               st_nxt.rdata[ast_pkg::TX_ON_BIT]   = st_r.tx_on;
               st_nxt.rdata[ast_pkg::BRK_REQ_BIT] = st_r.brk_req;
            end
            ast_pkg::OFS_STAT1: begin
               // Status read with the buffer empty arms the next data write
               st_nxt.rdata[ast_pkg::TBE_BIT]  = !st_r.full;
               st_nxt.rdata[ast_pkg::DONE_BIT] = st_r.done;
               if (!st_r.full) begin
                  st_nxt.armed = 1'b1;
               end
            end
            ast_pkg::OFS_STAT2: begin
               st_nxt.rdata[ast_pkg::LONG_BRK_BIT] = st_r.lng;
            end
            ast_pkg::OFS_CTRL3: begin
               st_nxt.rdata[ast_pkg::T8_BIT]  = st_r.t8;
               st_nxt.rdata[ast_pkg::POL_BIT] = st_r.pol;
            end
            default: begin
               // Data port reads the receive buffer
               st_nxt.rdata = rx_data_i;
            end
         endcase
      end

      // Register writes
      if (bus_i.wr) begin
         unique case (bus_i.addr)
            ast_pkg::OFS_BAUD_HI: begin
               st_nxt.sbr[12:8] = bus_i.wdata[4:0];
               st_nxt.two       = bus_i.wdata[ast_pkg::TWO_STOP_BIT];
            end
            ast_pkg::OFS_BAUD_LO: begin
               st_nxt.sbr[7:0] = bus_i.wdata;
            end
            ast_pkg::OFS_CTRL1: begin
               st_nxt.nine = bus_i.wdata[ast_pkg::NINE_BIT];
            end
            ast_pkg::OFS_CTRL2: begin
               st_nxt.tx_on   = bus_i.wdata[ast_pkg::TX_ON_BIT];
               st_nxt.brk_req = bus_i.wdata[ast_pkg::BRK_REQ_BIT];
               // Rising request queues one break
               if (bus_i.wdata[ast_pkg::BRK_REQ_BIT] && !st_r.brk_req) begin
                  st_nxt.brk_q = 1'b1;
                  st_nxt.done  = done_set; // Set wins over clear
               end
               // Off-to-on queues one idle frame
               if (bus_i.wdata[ast_pkg::TX_ON_BIT] && !st_r.tx_on) begin
                  st_nxt.idle_q = 1'b1;
                  st_nxt.done   = done_set; // Set wins over clear
               end
            end
            ast_pkg::OFS_STAT2: begin
               st_nxt.lng = bus_i.wdata[ast_pkg::LONG_BRK_BIT];
            end
            ast_pkg::OFS_CTRL3: begin
               st_nxt.t8  = bus_i.wdata[ast_pkg::T8_BIT];
               st_nxt.pol = bus_i.wdata[ast_pkg::POL_BIT];
            end
            ast_pkg::OFS_DATA: begin
               // Write lands only after a status read
               if (st_r.armed) begin
                  st_nxt.tbuf    = bus_i.wdata;
                  st_nxt.tbuf_t8 = st_r.t8;
                  st_nxt.full    = 1'b1;
                  st_nxt.done    = done_set; // Set wins over clear
                  st_nxt.armed   = 1'b0;
               end
            end
            default: begin
               // Status register one is read only
            end
         endcase
      end

      // Pin kept while on or while work remains
      st_nxt.own = st_nxt.tx_on || st_nxt.idle_q || st_nxt.brk_q
                   || (st_nxt.mode != ast_pkg::MODE_IDLE);
      // Output level, inverted on request
      st_nxt.txd = st_nxt.line ^ st_nxt.pol;
   end

   // ****************************************************
   // State register
   // ****************************************************
   // Reset: line high, buffer empty, done set
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r      <= '0;
         st_r.sbr  <= ast_pkg::SBR_RST;
         st_r.mode <= ast_pkg::MODE_IDLE;
         st_r.done <= 1'b1;
         st_r.line <= 1'b1;
         st_r.txd  <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rd_data_o = st_r.rdata;
   assign txd_o     = st_r.txd;
   assign txd_oe_o  = st_r.own;

   // ****************************************************
   // Assertions
   // ****************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   // Control write raising the break request bit
   sequence s_ctl_rise(int b);
      bus_i.wr && bus_i.addr == ast_pkg::OFS_CTRL2 && bus_i.wdata[b]
      && !st_r.brk_req && b == ast_pkg::BRK_REQ_BIT;
   endsequence
   // Data load on a tick
   sequence s_data_load;
      bit_tick && st_r.cnt == 4'h0 && !st_r.idle_q && !st_r.brk_q
      && st_r.full && st_r.tx_on;
   endsequence

   property p_idle_level;
      (st_r.mode == ast_pkg::MODE_IDLE && !bit_tick && $stable(st_r.pol))
         |=> txd_o == !st_r.pol;
   endproperty
   a_idle_level: assert property (p_idle_level) else $error("idle level wrong");

   property p_start_lsb;
      s_data_load ##1 (st_r.line == 1'b0 && !bit_tick)[*1]
         |-> st_r.sh[0] == $past(st_r.tbuf[0], 1);
   endproperty
   a_start_lsb: assert property (p_start_lsb) else $error("frame start wrong");

   property p_load_empties;
      s_data_load |=> !st_r.full && st_r.mode == ast_pkg::MODE_DATA
         && st_r.cnt == ast_pkg::frame_len(st_r.nine, st_r.two) - 4'h1;
   endproperty
   a_load_empties: assert property (p_load_empties) else $error("load wrong");

   property p_done_cause;
      $rose(st_r.done) |-> $past(bit_tick) && st_r.mode == ast_pkg::MODE_IDLE
         && st_r.line;
   endproperty
   a_done_cause: assert property (p_done_cause) else $error("done set wrongly");

   property p_pin_hold;
      $fell(txd_oe_o) |-> st_r.mode == ast_pkg::MODE_IDLE && !st_r.idle_q
         && !st_r.brk_q && !st_r.tx_on;
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("pin released early");

   property p_break_len;
      ld_brk |=> st_r.line == 1'b0 && st_r.cnt ==
         ast_pkg::break_len(st_r.nine, st_r.two, st_r.lng) - 4'h1;
   endproperty
   a_break_len: assert property (p_break_len) else $error("break length wrong");

   property p_break_queue;
      s_ctl_rise(ast_pkg::BRK_REQ_BIT) |=> st_r.brk_q && txd_oe_o;
   endproperty
   a_break_queue: assert property (p_break_queue) else $error("break not queued");

   property p_break_again;
      (ld_brk && st_r.brk_req) |=> st_r.brk_q;
   endproperty
   a_break_again: assert property (p_break_again) else $error("no repeat break");

   property p_idle_queue;
      (bus_i.wr && bus_i.addr == ast_pkg::OFS_CTRL2
       && bus_i.wdata[ast_pkg::TX_ON_BIT] && !st_r.tx_on) |=> st_r.idle_q && txd_oe_o;
   endproperty
   a_idle_queue: assert property (p_idle_queue) else $error("idle not queued");

   property p_bit_pace;
      (st_r.cnt != 4'h0 && !bit_tick) |=> $stable(st_r.line);
   endproperty
   a_bit_pace: assert property (p_bit_pace) else $error("bit changed off tick");

   property p_done_wins;
      done_set |=> st_r.done;
   endproperty
   a_done_wins: assert property (p_done_wins) else $error("done flag lost");

   property p_mark_frame;
      ld_mark |=> st_r.line && st_r.mode == ast_pkg::MODE_MARK
         && st_r.cnt == ast_pkg::frame_len(st_r.nine, st_r.two) - 4'h1;
   endproperty
   a_mark_frame: assert property (p_mark_frame) else $error("idle frame wrong");

   property p_load_match;
      s_data_load |-> ld_data;
   endproperty
   a_load_match: assert property (p_load_match) else $error("data not loaded");
endmodule // ast_tx
`default_nettype wire

// ==== ast_pkg.sv ====
// Constants, types and helpers for the serial transmitter.
// Assumes one bus-rate clock and the plain register port.
`default_nettype none
package ast_pkg;
   // ****************************************************
   // Register offsets
   // ****************************************************
   localparam int unsigned ADDR_W   = 3;           // Register address width
   localparam logic [2:0] OFS_BAUD_HI = 3'h0;      // baud_high_reg
   localparam logic [2:0] OFS_BAUD_LO = 3'h1;      // Baud modulus low byte
   localparam logic [2:0] OFS_CTRL1   = 3'h2;      // Format control
   localparam logic [2:0] OFS_CTRL2   = 3'h3;      // control_reg_two
   localparam logic [2:0] OFS_STAT1   = 3'h4;      // status_reg_one
   localparam logic [2:0] OFS_STAT2   = 3'h5;      // status_reg_two
   localparam logic [2:0] OFS_CTRL3   = 3'h6;      // control_reg_three
   localparam logic [2:0] OFS_DATA    = 3'h7;      // data_port

   // ****************************************************
   // Field positions
   // ****************************************************
   localparam int unsigned TWO_STOP_BIT  = 5;      // In baud_high_reg
   localparam int unsigned NINE_BIT      = 4;      // In format control
   localparam int unsigned TX_ON_BIT     = 3;      // In control_reg_two
   localparam int unsigned BRK_REQ_BIT   = 0;      // In control_reg_two
   localparam int unsigned TBE_BIT       = 7;      // In status_reg_one
   localparam int unsigned DONE_BIT      = 6;      // In status_reg_one
   localparam int unsigned LONG_BRK_BIT  = 2;      // In status_reg_two
   localparam int unsigned T8_BIT        = 6;      // In control_reg_three
   localparam int unsigned POL_BIT       = 4;      // In control_reg_three

   // ****************************************************
   // Reset values and timing
   // ****************************************************
   localparam int unsigned SBR_W      = 13;        // Baud modulus width
   localparam logic [12:0] SBR_RST    = 13'h0004;  // Modulus after reset
   localparam int unsigned OVERSAMPLE = 16;        // Baud clocks per bit
   localparam int unsigned FRAME_W    = 12;        // Longest shifter
   localparam logic [3:0]  BASE_LEN   = 4'ha;      // Start, 8 data, stop
   localparam logic [3:0]  LONG_EXTRA = 4'h3;      // Added by long break

   // ****************************************************
   // Types
   // ****************************************************
   // What the shifter is sending
   typedef enum logic [1:0] {MODE_IDLE, MODE_DATA, MODE_BREAK, MODE_MARK} ast_mode_e;

   // One register port request
   typedef struct packed {
      logic [2:0] addr;                            // Register offset
      logic [7:0] wdata;                           // Write data
      logic       wr;                              // Write strobe
      logic       rd;                              // Read strobe
   } ast_bus_s;

   // Character length in bit times
   function automatic logic [3:0] frame_len(input logic nine, input logic two);
      frame_len = BASE_LEN + {3'h0, nine} + {3'h0, two};
   endfunction

   // Break length in bit times
   function automatic logic [3:0] break_len(input logic nine, input logic two,
                                            input logic lng);
      break_len = frame_len(nine, two) + (lng ? LONG_EXTRA : 4'h0);
   endfunction
endpackage
`default_nettype wire

// ==== ast_baud_gen.sv ====
// Baud divider: one bit-rate pulse per OVERSAMPLE modulus periods.
// Assumes the modulus comes from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ast_baud_gen #(
   parameter int unsigned SBR_W = ast_pkg::SBR_W,       // Modulus width
   parameter int unsigned OS    = ast_pkg::OVERSAMPLE   // Sub-ticks per bit
) (
   input  wire logic             ref_clk_i,   // Bus-rate clock
   input  wire logic             reset_n_i,   // Async reset, active low
   input  wire logic [SBR_W-1:0] sbr_i,       // Modulus, zero stops
   output var  logic             bit_tick_o   // One pulse per bit time
);
   // Refuse shapes the counters cannot serve
   if (SBR_W < 1 || SBR_W > 16 || OS < 2 || OS > 16) begin : g_chk
      $error("ast_baud_gen: unsupported parameters");
   end

   // Divider state
   typedef struct packed {
      logic [SBR_W-1:0] cnt;                  // Modulus counter
      logic [3:0]       sub;                  // Sub-tick counter
      logic             tick;                 // Registered pulse
   } ast_baud_s;

   ast_baud_s st_r;                           // Current state
   ast_baud_s st_nxt;                         // Next state

   // ****************************************************
   // Divider
   // ****************************************************
   // Bus clock only; modulus zero holds the divider off
   always_comb begin
      st_nxt      = st_r;
      st_nxt.tick = 1'b0;
      if (sbr_i == '0) begin
         st_nxt.cnt = '0;
         st_nxt.sub = 4'h0;
      end else if (st_r.cnt >= sbr_i - SBR_W'(1)) begin
         st_nxt.cnt = '0;
         if (st_r.sub == 4'(OS - 1)) begin
            st_nxt.sub  = 4'h0;
            st_nxt.tick = 1'b1;
         end else begin
            st_nxt.sub = st_r.sub + 4'h1;
         end
      end else begin
         st_nxt.cnt = st_r.cnt + SBR_W'(1);
      end
   end

   // State register
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bit_tick_o = st_r.tick;
endmodule // ast_baud_gen
`default_nettype wire

// ==== ast_rx_model.sv ====
// Remote serial receiver model that watches the transmit line.
// Assumes an 8N1 frame and a bit time of BIT reference clocks.
`timescale 1ns/1ps
`default_nettype none
module ast_rx_model #(
   parameter int unsigned BIT = 16                 // Clocks per bit time
) (
   input  wire logic       ref_clk_i,              // Shared clock
   input  wire logic       line_i,                 // Serial line in
   output var  logic [7:0] byte_o,                 // Last byte seen
   output var  logic [7:0] count_o,                // Frames seen
   output var  logic       stop_bad_o              // Stop bit was low
);
   // ****************************************************
   // Mid-bit sampler, rate matched exactly
   // ****************************************************
   initial begin
      byte_o = 8'h00;
      count_o = 8'h00;
      stop_bad_o = 1'b0;
      forever begin
         @(negedge line_i);                        // Start edge
         repeat (BIT / 2) @(posedge ref_clk_i);
         if (line_i === 1'b0) begin                // Real start bit
            for (int i = 0; i < 8; i++) begin
               repeat (BIT) @(posedge ref_clk_i);
               byte_o[i] = line_i;
            end
            repeat (BIT) @(posedge ref_clk_i);
            stop_bad_o = (line_i !== 1'b1);
            count_o = count_o + 8'h01;
         end
      end
   end
endmodule // ast_rx_model
`default_nettype wire

// ==== async_serial_transmitter_tb.sv ====
// Self-checking bench for the serial transmitter.
// Assumes modulus 1, so one bit time is 16 clocks.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) checks++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end
module async_serial_transmitter_tb;
   logic              ref_clk_i;                   // Bus clock
   logic              reset_n_i;                   // Reset, active low
   ast_pkg::ast_bus_s bus;                         // Register request
   logic [7:0]        rx_data;                     // Receive buffer
   logic [7:0]        rd_data_o;                   // Read data
   logic              txd_o;                       // Serial line
   logic              txd_oe_o;                    // Pin ownership
   logic [7:0]        rx_byte;                     // Model byte
   logic [7:0]        rx_count;                    // Model frames
   logic              rx_stop_bad;                 // Model stop error
   logic              far_line;                    // Line the far side sees
   int                bad_count;                   // Mismatches
   int                checks;                      // Comparisons
   logic [7:0]        v;                           // Read value
   int                n;                           // Run length
   logic [15:0]       rows [4] = '{16'h5555, 16'ha3a3, 16'h0000, 16'hffff};

   ast_tx i_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .bus_i(bus),
      .rx_data_i(rx_data), .rd_data_o(rd_data_o), .txd_o(txd_o), .txd_oe_o(txd_oe_o));
   ast_rx_model i_far (.ref_clk_i(ref_clk_i), .line_i(far_line), .byte_o(rx_byte),
      .count_o(rx_count), .stop_bad_o(rx_stop_bad));
   // Released pin is parked high by the port logic
   assign far_line = txd_oe_o ? txd_o : 1'b1;

   // ****************************************************
   // Bus and line tasks
   // ****************************************************
   task automatic close_out();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge ref_clk_i);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge ref_clk_i);
      bus.rd <= 1'b0;
      #1 d = rd_data_o;                            // Only valid this cycle
   endtask
   task automatic wait_lvl(input logic l);         // Bounded level wait
      int k = 0;
      while (txd_o !== l && k < 800) begin
         @(negedge ref_clk_i);
         k++;
      end
      if (k >= 800) begin
         bad_count++;
         $display("[FAIL] line wait timed out");
         close_out();
      end
   endtask
   task automatic run_len(input logic l, output int c);
      c = 0;
      wait_lvl(l);
      while (txd_o === l && c < 800) begin
         @(negedge ref_clk_i);
         c++;
      end
   endtask
   task automatic wait_rx();                       // Next frame at far side
      logic [7:0] c0 = rx_count;
      int k = 0;
      while (rx_count === c0 && k < 800) begin
         @(negedge ref_clk_i);
         k++;
      end
      if (k >= 800) begin
         bad_count++;
         $display("[FAIL] receive timed out");
         close_out();
      end
   endtask

   // ****************************************************
   // Clock, reset and stimulus
   // ****************************************************
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      bad_count = 0;
      checks = 0;
      bus = '0;
      rx_data = 8'h5a;
      reset_n_i = 1'b0;
      repeat (4) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      #1 `CHK("txd", 1'b1, txd_o)
      `CHK("oe", 1'b0, txd_oe_o)
      `CHK("rd idle", 8'h00, rd_data_o)
      rd(ast_pkg::OFS_STAT1, v);
      `CHK("status", 8'hc0, v)
      @(posedge ref_clk_i);
      #1 `CHK("rd stands", 8'h00, rd_data_o)
      wr(ast_pkg::OFS_BAUD_HI, 8'h00);
      wr(ast_pkg::OFS_BAUD_LO, 8'h01);
      rd(ast_pkg::OFS_BAUD_LO, v);
      `CHK("modulus", 8'h01, v)
      rd(ast_pkg::OFS_DATA, v);
      `CHK("rx read", 8'h5a, v)
      wr(ast_pkg::OFS_CTRL2, 8'h08);
      #1 `CHK("oe on", 1'b1, txd_oe_o)
      foreach (rows[i]) begin                      // Ordinary bytes
         rd(ast_pkg::OFS_STAT1, v);
         wr(ast_pkg::OFS_DATA, rows[i][15:8]);
         wait_rx();
         `CHK("byte", rows[i][7:0], rx_byte)
         `CHK("stop", 1'b0, rx_stop_bad)
      end
      repeat (20) @(negedge ref_clk_i);
      wr(ast_pkg::OFS_DATA, 8'h11);                // No status read first
      rd(ast_pkg::OFS_STAT1, v);
      `CHK("drop", 8'hc0, v)
      wr(ast_pkg::OFS_DATA, 8'h00);                // Idle queued mid-frame
      wait_lvl(1'b0);
      wr(ast_pkg::OFS_CTRL2, 8'h00);
      #1 `CHK("oe brief off", 1'b1, txd_oe_o)
      wr(ast_pkg::OFS_CTRL2, 8'h08);
      rd(ast_pkg::OFS_STAT1, v);
      wr(ast_pkg::OFS_DATA, 8'h3c);
      rd(ast_pkg::OFS_STAT1, v);
      `CHK("full", 8'h00, v)
      run_len(1'b1, n);
      `CHK("idle gap", 176, n)
      wait_rx();
      `CHK("after idle", 8'h3c, rx_byte)
      rd(ast_pkg::OFS_STAT1, v);
      wr(ast_pkg::OFS_DATA, 8'hf0);                // Single break behind data
      wait_lvl(1'b0);
      wr(ast_pkg::OFS_CTRL2, 8'h09);
      wr(ast_pkg::OFS_CTRL2, 8'h08);
      wait_lvl(1'b1);
      run_len(1'b0, n);
      `CHK("break", 160, n)
      for (int k = 0; k < 8; k++) begin            // Every break format
         wr(ast_pkg::OFS_CTRL1, {3'h0, k[0], 4'h0});
         wr(ast_pkg::OFS_BAUD_HI, {2'h0, k[1], 5'h00});
         wr(ast_pkg::OFS_STAT2, {5'h00, k[2], 2'h0});
         wr(ast_pkg::OFS_CTRL2, 8'h09);
         fork
            run_len(1'b0, n);
            begin
               wait_lvl(1'b0);
               wr(ast_pkg::OFS_CTRL2, 8'h08);
            end
         join
         `CHK("two breaks", 32 * (10 + k[0] + k[1] + 3 * k[2]), n)
      end
      // Nine bits and two stops stay set from the last format
      wr(ast_pkg::OFS_CTRL3, 8'h40);               // Ninth bit one
      rd(ast_pkg::OFS_STAT1, v);
      wr(ast_pkg::OFS_DATA, 8'h00);
      fork
         run_len(1'b0, n);
         begin
            wait_lvl(1'b0);
            wr(ast_pkg::OFS_CTRL3, 8'h00);         // Ninth bit zero
            rd(ast_pkg::OFS_STAT1, v);
            wr(ast_pkg::OFS_DATA, 8'h00);
         end
      join
      `CHK("nine low", 144, n)
      run_len(1'b1, n);
      `CHK("ninth and stops", 48, n)
      run_len(1'b0, n);
      `CHK("nine zero", 160, n)
      wr(ast_pkg::OFS_CTRL3, 8'h10);
      repeat (3) @(negedge ref_clk_i);
      `CHK("inverted idle", 1'b0, txd_o)
      wr(ast_pkg::OFS_CTRL2, 8'h00);
      #1 `CHK("oe held", 1'b1, txd_oe_o)
      repeat (48) @(negedge ref_clk_i);
      `CHK("oe released", 1'b0, txd_oe_o)
      close_out();
   end
endmodule // async_serial_transmitter_tb
`default_nettype wire
